/* File: logic/csd_pkg.sv */
/*
  Package for the chip select decoder: register offsets, field positions,
  reset values and encodings of the four decode entries.
  Assumes a 32-bit AHB-Lite register bus and a single system clock.
*/
package csd_pkg;

  // Number of decode entries.
  localparam int unsigned CSD_ENTRIES = 4;

  // Register byte offsets; each entry owns a mask word and a base word.
  localparam logic [7:0] CSD_MASK0_OFS  = 8'h40;
  localparam logic [7:0] CSD_BASE0_OFS  = 8'h44;
  localparam logic [7:0] CSD_ENTRY_STEP = 8'h08;
  localparam logic [7:0] CSD_STATUS_OFS = 8'h60;

  // Field positions of the mask word.
  localparam int unsigned CSD_BLK_LSB   = 8;
  localparam int unsigned CSD_SPC_LSB   = 4;
  localparam int unsigned CSD_DLY_LSB   = 2;
  localparam int unsigned CSD_WID_LSB   = 0;

  // Field positions of the base word.
  localparam int unsigned CSD_WG_BIT    = 3;
  localparam int unsigned CSD_QF_BIT    = 2;
  localparam int unsigned CSD_SKIP_BIT  = 1;
  localparam int unsigned CSD_VALID_BIT = 0;

  // Width select encodings.
  localparam logic [1:0] CSD_WID_DMA32 = 2'h0;
  localparam logic [1:0] CSD_WID_16    = 2'h1;
  localparam logic [1:0] CSD_WID_8     = 2'h2;
  localparam logic [1:0] CSD_WID_EXT   = 2'h3;

  // Boot behaviour of entry zero: 16-bit width and three wait states.
  localparam logic [1:0] CSD_BOOT_WID  = 2'h1;
  localparam logic [1:0] CSD_BOOT_DLY  = 2'h3;
  localparam logic [2:0] CSD_BOOT_CYC  = 3'h4;

  // Space codes that denote a CPU space access.
  localparam logic [3:0] CSD_CPU_SPC_A = 4'h7;
  localparam logic [3:0] CSD_CPU_SPC_B = 4'hF;

  // Quick-finish cycle length in clocks, and the least normal length.
  localparam logic [2:0] CSD_QF_CLKS   = 3'h2;
  localparam logic [2:0] CSD_MIN_CLKS  = 3'h3;

  // Bus cycle sequencer states.
  typedef enum logic [2:0] {
    CSD_IDLE = 3'b001,
    CSD_WAIT = 3'b010,
    CSD_DONE = 3'b100
  } csd_state_type;

endpackage : csd_pkg

/* File: logic/csd_entry_match.sv */
/*
  One decode entry: compares the address and space code of a bus cycle
  against the programmed base under the per-bit masks.
  Assumes inputs are synchronous to mclk; result is registered.
*/
`timescale 1ns/1ps
`default_nettype none
module csd_entry_match (
  input  wire  logic        mclk,
  input  wire  logic        rst,
  input  wire  logic [31:0] busAddr,
  input  wire  logic [3:0]  busSpace,
  input  wire  logic [31:0] maskWord,
  input  wire  logic [31:0] baseWord,
  input  wire  logic        globalMode,
  output logic              hit
);
  import csd_pkg::*;

  logic [23:0] addrDiff;   // Bits that differ between address and base.
  logic [3:0]  spcDiff;    // Space code bits that differ.
  logic        cpuSpace;   // Cycle is a CPU space access.
  logic        hitNxt;     // Combinational match result.

  // Each masked block bit doubles the block, so size is two to (masked+8). [RULE1]
  // Masked bits become don't care; any pattern of mask bits is legal. [RULE2] [RULE3] [RULE5]
  always_comb begin
    addrDiff = (busAddr[31:8] ^ baseWord[31:8]) & ~maskWord[31:CSD_BLK_LSB];
    spcDiff  = (busSpace ^ baseWord[7:4]) & ~maskWord[CSD_SPC_LSB +: 4];
    cpuSpace = (busSpace == CSD_CPU_SPC_A) || (busSpace == CSD_CPU_SPC_B);
    // Global mode matches everything; otherwise only a valid entry matches. [RULE13] [RULE16] [RULE20]
    if (globalMode) begin
      hitNxt = 1'b1;
    end else begin
      hitNxt = baseWord[CSD_VALID_BIT] && (addrDiff == 24'h000000) && (spcDiff == 4'h0)
               && !(baseWord[CSD_SKIP_BIT] && cpuSpace); // [RULE19]
    end
  end

  // Registered so the select line comes straight from a flip-flop.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hit <= 1'b0;
    end else begin
      hit <= hitNxt;
    end
  end

endmodule : csd_entry_match
`default_nettype wire

/* File: logic/csd_decoder.sv */
/*
  Chip select decoder with four entries, an internal size acknowledge
  generator with wait states, write guard fault and boot select mode.
  Assumes an AHB-Lite master for registers and a simple bus cycle
  request (busStart with address, space code and direction) held stable
  by the internal master until the cycle ends.
*/
// What this block does
// RULE1: block size is two to (mask count+8)
// RULE2: set mask bit makes base bit don't care
// RULE3: mask bits may form any pattern
// RULE4: block mask register readable and writable anytime
// RULE5: space code mask bits are don't care
// RULE6: delay code gives zero to three waits
// RULE7: delay used only internal ack, no quick-finish
// RULE8: early external acknowledge ends the cycle
// RULE9: width codes: 16-bit, 8-bit, external, DMA32
// RULE10: external width: no internal ack, delay ignored
// RULE11: lowest-numbered matching entry wins
// RULE12: four boot cycles with boot select after reset
// RULE13: entry zero global, 16-bit, three waits
// RULE14: software loads entry zero base before valid
// RULE15: global mode ends until next reset
// RULE16: no select until valid; reset clears valid
// RULE17: write to guarded range gives bus fault
// RULE18: quick-finish ends after two clocks
// RULE19: skip CPU space suppresses the select
// RULE20: compare unmasked address and space each cycle
`timescale 1ns/1ps
`default_nettype none
module csd_decoder #(
  parameter int unsigned ENTRIES = csd_pkg::CSD_ENTRIES
) (
  input  wire  logic        mclk,
  input  wire  logic        rst,
  // AHB-Lite register slave.
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  // Bus cycle request from the internal master.
  input  wire  logic        busStart,
  input  wire  logic [31:0] busAddr,
  input  wire  logic [3:0]  busSpace,
  input  wire  logic        busWrite,
  input  wire  logic        extAck,
  // Outputs toward memories and the internal master.
  output logic [3:0]        selectN,
  output logic              bootSelect,
  output logic              sizeAck,
  output logic [1:0]        ackWidth,
  output logic              busFault,
  output logic              cycleDone
);
  import csd_pkg::*;

  logic [31:0]   maskReg_r [ENTRIES];  // Mask words per entry.
  logic [31:2]   baseHi_r [ENTRIES];   // Base address, space code, guard, quick finish.
  logic [ENTRIES-1:0] skipFlag_r;      // Skip CPU space flags, cleared by reset.
  logic [ENTRIES-1:0] validFlag_r;     // Valid flags, cleared by reset.
  logic [31:0]   baseReg [ENTRIES];    // Base words assembled from the parts above.
  logic          globalMode_r;         // Entry zero still in boot mode.
  logic [2:0]    bootCount_r;          // Boot cycles run since reset.
  logic [ENTRIES-1:0] hit;             // Registered per-entry matches.
  logic [31:0]   maskEff [ENTRIES];    // Masks as seen by the matchers.
  csd_state_type state_r;              // Bus cycle sequencer.
  logic [2:0]    waitCnt_r;            // Clocks spent in the cycle.
  logic [2:0]    waitGoal_r;           // Clocks after which internal ack fires.
  logic          intAck_r;             // Selected entry gives internal ack.
  logic          busWrite_r;           // Direction latched at cycle start.
  logic [1:0]    selIdx;               // Lowest matching entry index.
  logic          anyHit;               // Some entry matched.
  // AHB data-phase capture.
  logic          dpWrite_r;
  logic          dpRead_r;
  logic [7:0]    dpAddr_r;

  // Base words as the rest of the block sees them. The flag bits live in
  // their own registers because only they are cleared by reset; keeping
  // them apart gives every register exactly one process that writes it.
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      baseReg[i] = {baseHi_r[i], skipFlag_r[i], validFlag_r[i]};
    end
  end

  // Entry zero behaves as 16-bit with three waits while in global mode.
  always_comb begin
    for (int i = 0; i < ENTRIES; i++) begin
      maskEff[i] = maskReg_r[i];
    end
    if (globalMode_r) begin
      maskEff[0][CSD_WID_LSB +: 2] = CSD_BOOT_WID; // [RULE13]
      maskEff[0][CSD_DLY_LSB +: 2] = CSD_BOOT_DLY;
    end
  end

  // One comparator per entry; only entry zero ever sees global mode.
  for (genvar g = 0; g < ENTRIES; g++) begin : gEntry
    csd_entry_match uMatch (
      .mclk       (mclk),
      .rst        (rst),
      .busAddr    (busAddr),
      .busSpace   (busSpace),
      .maskWord   (maskEff[g]),
      .baseWord   (baseReg[g]),
      .globalMode ((g == 0) ? globalMode_r : 1'b0),
      .hit        (hit[g])
    );
  end

  // Priority pick: the lowest-numbered hit wins. [RULE11]
  always_comb begin
    selIdx = 2'h0;
    anyHit = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        selIdx = 2'(i);
        anyHit = 1'b1;
      end
    end
  end

  // AHB address phase capture; every access finishes with no wait, OKAY.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dpWrite_r <= 1'b0;
      dpRead_r  <= 1'b0;
      dpAddr_r  <= 8'h00;
    end else begin
      if (hready) begin
        dpWrite_r <= hsel && htrans[1] && hwrite;
        dpRead_r  <= hsel && htrans[1] && !hwrite;
        dpAddr_r  <= haddr[7:0];
      end
    end
  end

  // Register writes, accepted at any time regardless of bus cycles. [RULE4]
  // Reset clears only the valid and skip flags; other bits keep contents. [RULE16]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      validFlag_r <= {ENTRIES{1'b0}};
      skipFlag_r  <= {ENTRIES{1'b0}};
    end else if (dpWrite_r) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (dpAddr_r == CSD_BASE0_OFS + 8'(i) * CSD_ENTRY_STEP) begin
          validFlag_r[i] <= hwdata[CSD_VALID_BIT];
          skipFlag_r[i]  <= hwdata[CSD_SKIP_BIT];
        end
      end
    end
  end

  // Unreset portion of the base and mask words.
  always_ff @(posedge mclk) begin
    if (dpWrite_r) begin
      for (int i = 0; i < ENTRIES; i++) begin
        if (dpAddr_r == CSD_MASK0_OFS + 8'(i) * CSD_ENTRY_STEP) begin
          maskReg_r[i] <= {hwdata[31:4], hwdata[3:0]};
        end
        if (dpAddr_r == CSD_BASE0_OFS + 8'(i) * CSD_ENTRY_STEP) begin
          baseHi_r[i] <= hwdata[31:2];
        end
      end
    end
  end

  // Read data is registered; unmapped offsets read zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h00000000;
      for (int i = 0; i < ENTRIES; i++) begin
        if (haddr[7:0] == CSD_MASK0_OFS + 8'(i) * CSD_ENTRY_STEP) begin
          hrdata <= maskReg_r[i];
        end
        if (haddr[7:0] == CSD_BASE0_OFS + 8'(i) * CSD_ENTRY_STEP) begin
          hrdata <= baseReg[i];
        end
      end
      if (haddr[7:0] == CSD_STATUS_OFS) begin
        hrdata <= {27'h0000000, bootCount_r, globalMode_r, 1'b0};
      end
    end
  end

  // Zero-wait OKAY slave.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Global mode lasts until entry zero becomes valid, then only reset
  // restores it; software must load the base first. [RULE15] [RULE14]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      globalMode_r <= 1'b1;
    end else if (validFlag_r[0]) begin
      globalMode_r <= 1'b0;
    end
  end

  // Count the boot fetch cycles; boot select flags the first four. [RULE12]
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bootCount_r <= 3'h0;
    end else if (state_r == CSD_DONE && bootCount_r != CSD_BOOT_CYC) begin
      bootCount_r <= bootCount_r + 3'h1;
    end
  end

  // Bus cycle sequencer: sample match one clock after start, then count.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r    <= CSD_IDLE;
      waitCnt_r  <= 3'h0;
      waitGoal_r <= 3'h0;
      intAck_r   <= 1'b0;
      busWrite_r <= 1'b0;
    end else begin
      case (state_r)
        CSD_IDLE: begin
          waitCnt_r <= 3'h0;
          if (busStart) begin
            state_r    <= CSD_WAIT;
            busWrite_r <= busWrite;
          end
        end
        CSD_WAIT: begin
          waitCnt_r <= waitCnt_r + 3'h1;
          if (waitCnt_r == 3'h0) begin
            // Quick-finish overrides delay; external width ignores it. [RULE7] [RULE10] [RULE18]
            intAck_r <= anyHit && (maskEff[selIdx][CSD_WID_LSB +: 2] != CSD_WID_EXT);
            if (baseReg[selIdx][CSD_QF_BIT] && !globalMode_r) begin
              waitGoal_r <= CSD_QF_CLKS - 3'h1;
            end else begin
              // Delay code adds 0..3 waits on top of three clocks. [RULE6]
              waitGoal_r <= CSD_MIN_CLKS - 3'h1 + {1'b0, maskEff[selIdx][CSD_DLY_LSB +: 2]};
            end
            // Guarded range refuses writes at once with a fault. [RULE17]
            if (anyHit && busWrite_r && baseReg[selIdx][CSD_WG_BIT] && !globalMode_r) begin
              state_r <= CSD_DONE;
            end
          end else if (extAck || (intAck_r && waitCnt_r >= waitGoal_r)) begin
            state_r <= CSD_DONE; // [RULE8]
          end
        end
        CSD_DONE: begin
          state_r <= CSD_IDLE;
        end
        default: begin
          state_r <= CSD_IDLE;
        end
      endcase
    end
  end

  // Output strobes, all from flip-flops.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      selectN    <= 4'hF;
      bootSelect <= 1'b0;
      sizeAck    <= 1'b0;
      ackWidth   <= 2'h0;
      busFault   <= 1'b0;
      cycleDone  <= 1'b0;
    end else begin
      sizeAck   <= 1'b0;
      busFault  <= 1'b0;
      cycleDone <= 1'b0;
      if (state_r == CSD_WAIT && waitCnt_r != 3'h0) begin
        // Only the winning entry drives its line low. [RULE11]
        selectN    <= anyHit ? ~(4'h1 << selIdx) : 4'hF;
        bootSelect <= globalMode_r && (bootCount_r != CSD_BOOT_CYC); // [RULE12]
        if (extAck || (intAck_r && waitCnt_r >= waitGoal_r)) begin
          sizeAck   <= intAck_r && !extAck;
          ackWidth  <= maskEff[selIdx][CSD_WID_LSB +: 2]; // [RULE9]
          cycleDone <= 1'b1;
        end
      end else if (state_r == CSD_WAIT && anyHit && busWrite_r && !globalMode_r
                   && baseReg[selIdx][CSD_WG_BIT]) begin
        busFault  <= 1'b1; // [RULE17]
        cycleDone <= 1'b1;
      end else if (state_r != CSD_WAIT) begin
        selectN    <= 4'hF;
        bootSelect <= 1'b0;
      end
    end
  end

  // A set valid flag on entry zero must end global mode by the next clock.
  AST_GLOBAL_END: assert property (@(posedge mclk) disable iff (rst) // [RULE15]
    validFlag_r[0] |-> ##1 !globalMode_r)
    else $error("global mode survived valid flag");

  // Two select lines are never low together.
  AST_ONE_SELECT: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
    $onehot0(~selectN))
    else $error("more than one select asserted");

  // Internal acknowledge never comes from an external-width entry.
  AST_EXT_NO_ACK: assert property (@(posedge mclk) disable iff (rst) // [RULE10]
    sizeAck |-> ackWidth != CSD_WID_EXT)
    else $error("internal ack on external width");

  // An invalid entry one never selects outside global mode.
  AST_VALID_GATE: assert property (@(posedge mclk) disable iff (rst) // [RULE16]
    (!globalMode_r && !validFlag_r[1] && $stable(validFlag_r[1]))
    |=> selectN[1])
    else $error("select without valid");

  // An external ack ends the cycle on the next clock.
  AST_EARLY_END: assert property (@(posedge mclk) disable iff (rst) // [RULE8]
    (state_r == CSD_WAIT && waitCnt_r != 3'h0 && extAck) |=> cycleDone)
    else $error("external ack ignored");

  // A fault always ends the cycle and never comes with an acknowledge.
  AST_FAULT_END: assert property (@(posedge mclk) disable iff (rst) // [RULE17]
    busFault |-> cycleDone && !sizeAck)
    else $error("fault without cycle end");

  // Boot select only while global mode holds.
  AST_BOOT_MODE: assert property (@(posedge mclk) disable iff (rst) // [RULE12]
    bootSelect |-> $past(globalMode_r))
    else $error("boot select outside global mode");

  // Internal ack in global mode needs three waits: at least five clocks after start.
  AST_BOOT_WAITS: assert property (@(posedge mclk) disable iff (rst) // [RULE13]
    (state_r == CSD_IDLE && busStart && globalMode_r && !extAck) ##1 !extAck [*4]
    |-> !cycleDone)
    else $error("boot cycle too short");

endmodule : csd_decoder
`default_nettype wire

/* File: sim/csd_mem_model.sv */
/*
  Far-side responder for the chip select decoder: answers each bus cycle
  still open a set number of edges later with an external size acknowledge.
  Assumes busStart pulses one cycle and cycleDone marks the cycle end.
*/
`timescale 1ns/1ps
`default_nettype none
module csd_mem_model (
  input  wire  logic       mclk,
  input  wire  logic       rst,
  input  wire  logic       busStart,
  input  wire  logic       cycleDone,
  input  wire  logic [4:0] ackDly,
  output logic             extAck
);
  logic [4:0] cnt;   // Edges since the cycle started.
  logic       busy;  // A cycle is in flight.

  // The acknowledge is seen by the decoder at edge ackDly of the cycle.
  // It drops once the cycle ends, so a stale level never leaks forward.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt    <= 5'h00;
      busy   <= 1'b0;
      extAck <= 1'b0;
    end else if (busStart) begin
      cnt  <= 5'h00;
      busy <= 1'b1;
    end else if (cycleDone) begin
      busy   <= 1'b0;
      extAck <= 1'b0;
    end else begin
      cnt    <= cnt + 5'h01;
      extAck <= busy && (cnt + 5'h02 >= ackDly);
    end
  end
endmodule : csd_mem_model
`default_nettype wire

/* File: sim/csd_decoder_tb.sv */
/*
  Self-checking bench for the chip select decoder: an AHB-Lite master
  for the registers, a bus cycle driver and an external responder.
  Assumes the decoder answers register accesses with hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module csd_decoder_tb;
  import csd_pkg::*;
  logic        mclk, rst, hsel, hwrite, busStart, busWrite, extAck;
  logic [31:0] haddr, hwdata, hrdata, busAddr, rd;
  logic [1:0]  htrans, ackWidth, wid;
  logic [2:0]  hsize;
  logic [3:0]  busSpace, selectN, sel;
  logic        hready, hreadyout, hresp, bootSelect, sizeAck, busFault, cycleDone;
  logic        boot, sack, flt;
  logic [4:0]  ackDly;     // Responder delay; large keeps it out of the way.
  int          len, error_cnt, checks_done;

  assign hready = hreadyout;  // The one slave drives the bus ready.

  csd_decoder csd_decoder_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .busStart(busStart), .busAddr(busAddr), .busSpace(busSpace),
    .busWrite(busWrite), .extAck(extAck), .selectN(selectN),
    .bootSelect(bootSelect), .sizeAck(sizeAck), .ackWidth(ackWidth),
    .busFault(busFault), .cycleDone(cycleDone));
  csd_mem_model csd_mem_model_i (.mclk(mclk), .rst(rst), .busStart(busStart),
    .cycleDone(cycleDone), .ackDly(ackDly), .extAck(extAck));

  // Clock at 40 MHz.
  always #12.5 mclk = ~mclk;

  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // One single AHB-Lite word transfer; read data taken at the data edge.
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
    do begin @(posedge mclk); i++; end while (hready !== 1'b1 && i < 20);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge mclk); i++; end while (hready !== 1'b1 && i < 20);
    rd = hrdata;
    if (i >= 20) begin error_cnt++; stop_test(); end
  endtask : ahb

  // Programs one entry; the base goes in before its valid flag.
  task prog(input logic [7:0] n, input logic [31:0] m, input logic [31:0] b);
    ahb(1'b1, CSD_MASK0_OFS + n * CSD_ENTRY_STEP, m);
    ahb(1'b1, CSD_BASE0_OFS + n * CSD_ENTRY_STEP, b & 32'hFFFFFFFE);
    ahb(1'b1, CSD_BASE0_OFS + n * CSD_ENTRY_STEP, b);
  endtask : prog

  // Runs one bus cycle and records its length and what the decoder drove.
  task cyc(input logic [31:0] a, input logic [3:0] s, input logic w);
    @(posedge mclk);
    busStart <= 1'b1; busAddr <= a; busSpace <= s; busWrite <= w;
    @(posedge mclk);
    busStart <= 1'b0;
    len = 0; sel = 4'hF; boot = 1'b0; sack = 1'b0; flt = 1'b0; wid = 2'h0;
    do begin
      @(posedge mclk); #1; len++;
      sel &= selectN; boot |= bootSelect; flt |= busFault;
      if (sizeAck === 1'b1) begin sack = 1'b1; wid = ackWidth; end
    end while (cycleDone !== 1'b1 && len < 40);
    if (len >= 40) begin error_cnt++; stop_test(); end
    @(posedge mclk);
  endtask : cyc

  // Runs a read cycle and compares the select lines.
  task hit(input logic [31:0] a, input logic [3:0] s, input logic [3:0] e);
    cyc(a, s, 1'b0);
    `CHK(sel, e)
  endtask : hit

  // Boot: four global cycles, then global select without boot marking.
  task t_boot();
    for (int i = 0; i < 4; i++) begin
      cyc(32'h00000000 + 4 * i, 4'h6, 1'b0);
      `CHK(boot, 1'b1)
      `CHK(len, CSD_MIN_CLKS + CSD_BOOT_DLY)
      `CHK({sel, sack, wid}, {4'hE, 1'b1, CSD_WID_16})
    end
    hit(32'h12345678, 4'h5, 4'hE);
    `CHK(boot, 1'b0)
  endtask : t_boot

  // Mask read-back, an unmapped address, and the global mode flag.
  task t_regs();
    ahb(1'b1, CSD_MASK0_OFS + CSD_ENTRY_STEP, 32'hA5A5A5A5);
    ahb(1'b0, CSD_MASK0_OFS + CSD_ENTRY_STEP, 32'h0);
    `CHK(rd, 32'hA5A5A5A5)
    ahb(1'b0, 8'h70, 32'h0);
    `CHK(rd, 32'h00000000)
    `CHK(hresp, 1'b0)
    ahb(1'b0, CSD_STATUS_OFS, 32'h0);
    `CHK(rd[1], 1'b1)
  endtask : t_regs

  // Each width code except external (DMA32, 16-bit, 8-bit) with every delay code on entry zero.
  task t_delays();
    prog(8'h0, 32'h00FFFFF1, 32'hFF000001);
    for (int w = 0; w < 3; w++) begin
      for (int d = 0; d < 4; d++) begin
        ahb(1'b1, CSD_MASK0_OFS, 32'h00FFFFF0 | (d << 2) | w);
        cyc(32'hFF001234, 4'h1, 1'b0);
        `CHK(len, CSD_MIN_CLKS + d)
        `CHK({sel, sack, wid}, {4'hE, 1'b1, 2'(w)})
      end
    end
    ahb(1'b0, CSD_STATUS_OFS, 32'h0);
    `CHK(rd[1], 1'b0)
    hit(32'h00000010, 4'h5, 4'hF);
  endtask : t_delays

  // External acknowledge with external width and ahead of internal delay.
  task t_ext();
    for (int k = 3; k < 6; k += 2) begin
      ackDly <= 5'(k);
      for (int w = 1; w < 4; w += 2) begin
        ahb(1'b1, CSD_MASK0_OFS, 32'h00FFFFFC | w);
        cyc(32'hFF000040, 4'h2, 1'b0);
        `CHK(len, k)
        `CHK({sel, sack}, {4'hE, 1'b0})
      end
    end
    ackDly <= 5'h0A;
  endtask : t_ext

  // Quick finish overrides a three wait state delay.
  task t_qf();
    ahb(1'b1, CSD_MASK0_OFS, 32'h00FFFFFD);
    ahb(1'b1, CSD_BASE0_OFS, 32'hFF000005);
    cyc(32'hFF000080, 4'h1, 1'b0);
    `CHK(len, CSD_QF_CLKS)
    `CHK(sack, 1'b1)
    ahb(1'b1, CSD_BASE0_OFS, 32'hFF000001);
  endtask : t_qf

  // Scattered block mask, space mask, CPU space skip and priority.
  task t_match();
    prog(8'h1, 32'h00100121, 32'h00040051);
    hit(32'h000400FF, 4'h5, 4'hD);
    hit(32'h00040100, 4'h5, 4'hD);
    hit(32'h00140000, 4'h5, 4'hD);
    hit(32'h00040200, 4'h5, 4'hF);
    hit(32'h00040000, 4'h7, 4'hD);
    hit(32'h00040000, 4'h1, 4'hF);
    ahb(1'b1, CSD_BASE0_OFS + CSD_ENTRY_STEP, 32'h00040053);
    hit(32'h00040000, 4'h7, 4'hF);
    hit(32'h00040000, 4'h5, 4'hD);
    prog(8'h2, 32'h00FFFFF1, 32'hFF000001);
    hit(32'hFF000100, 4'h3, 4'hE);
  endtask : t_match

  // Invalid entry stays quiet; write guard faults writes, passes reads.
  task t_guard();
    ahb(1'b1, CSD_MASK0_OFS + 3 * CSD_ENTRY_STEP, 32'h000000F1);
    ahb(1'b1, CSD_BASE0_OFS + 3 * CSD_ENTRY_STEP, 32'h00200008);
    hit(32'h00200000, 4'h5, 4'hF);
    ahb(1'b1, CSD_BASE0_OFS + 3 * CSD_ENTRY_STEP, 32'h00200009);
    cyc(32'h00200010, 4'h5, 1'b1);
    `CHK({flt, sel, len}, {1'b1, 4'hF, 32'sd1})
    cyc(32'h00200010, 4'h5, 1'b0);
    `CHK({flt, sel}, {1'b0, 4'h7})
  endtask : t_guard

  // A second reset clears valid flags and restores global boot select.
  task t_reset();
    @(posedge mclk); rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    hit(32'h00040000, 4'h5, 4'hE);
    `CHK(boot, 1'b1)
  endtask : t_reset

  // Main sequence.
  initial begin
    mclk = 1'b0; rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
    haddr = 32'h0; hwdata = 32'h0; hsize = 3'h2; busStart = 1'b0;
    busWrite = 1'b0; busAddr = 32'h0; busSpace = 4'h0; ackDly = 5'h0A;
    error_cnt = 0; checks_done = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_boot(); t_regs(); t_delays(); t_ext(); t_qf(); t_match(); t_guard();
    t_reset();
    stop_test();
  end
endmodule : csd_decoder_tb
`default_nettype wire
